// ### shared/fuse_cfg_pkg.sv
// Constants and types for the fuse, signature and trim store
package fuse_cfg_pkg;

    // Factory values of the three fuse bytes and the lock byte (0 = programmed)
    localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
    localparam logic [7:0] FUSE_HIGH_RST = 8'hD9;
    localparam logic [7:0] FUSE_LOW_RST = 8'h62;
    localparam logic [7:0] LOCK_RST = 8'hFF;
    localparam logic [7:0] BLANK_BYTE = 8'hFF;

    // High fuse byte fields
    localparam int HI_RESET_PIN_DIS = 7;
    localparam int HI_DEBUG_ON = 6;
    localparam int HI_SERIAL_PROG = 5;
    localparam int HI_WDT_FORCED = 4;
    localparam int HI_EEPROM_KEEP = 3;
    localparam int HI_BOOT_SIZE_LSB = 1;
    localparam int HI_RESET_VECTOR = 0;

    // Low fuse byte fields
    localparam int LO_CLK_DIV8 = 7;
    localparam int LO_CLK_TO_PIN = 6;
    localparam int LO_STARTUP_LSB = 4;
    localparam int LO_CLK_SRC_LSB = 0;

    // Extended fuse byte fields
    localparam int EXT_BOD_LSB = 0;
    localparam int EXT_SELF_WRITE = 0;

    // Lock byte field
    localparam int LOCK_FIRST = 0;

    // Signature address space
    localparam logic [1:0] SIG_ADDR_0 = 2'h0;
    localparam logic [1:0] SIG_ADDR_1 = 2'h1;
    localparam logic [1:0] SIG_ADDR_2 = 2'h2;

    // Page geometry
    localparam int FLASH_WORD_BITS = 6;
    localparam int FLASH_PAGE_BITS = 8;
    localparam int FLASH_ADDR_W = FLASH_WORD_BITS + FLASH_PAGE_BITS;
    localparam int EE_BYTE_BITS = 2;
    localparam int EE_PAGE_BITS = 8;
    localparam int EE_ADDR_W = EE_BYTE_BITS + EE_PAGE_BITS;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_CHIP_ERASE = 3'h1,
        OP_WRITE_FUSE = 3'h2,
        OP_WRITE_LOCK = 3'h3,
        OP_READ_SIG = 3'h4,
        OP_READ_FUSE = 3'h5
    } op_t;

    typedef enum logic [1:0] {
        SEL_LOW = 2'h0,
        SEL_HIGH = 2'h1,
        SEL_EXT = 2'h2,
        SEL_LOCK = 2'h3
    } sel_t;

endpackage : fuse_cfg_pkg

// ### shared/fuse_latch_if.sv
// Carrier between the fuse store and its working latches
interface fuse_latch_if;
    logic [7:0] stored_low;
    logic [7:0] stored_high;
    logic [7:0] stored_ext;
    logic capture;
    logic [7:0] work_low;
    logic [7:0] work_high;
    logic [7:0] work_ext;

    modport store (output stored_low, stored_high, stored_ext, capture, input work_low, work_high, work_ext);
    modport latch (input stored_low, stored_high, stored_ext, capture, output work_low, work_high, work_ext);
endinterface : fuse_latch_if

// ### rtl/fuse_working_latch.sv
// Working latches that hold the fuse values seen by the chip
module fuse_working_latch
    import fuse_cfg_pkg::*;
(
    input wire logic clk_i,    // System clock
    input wire logic reset_i,  // Synchronous reset, active high
    fuse_latch_if.latch lat    // Stored values in, working values out
);

    // Between captures the working copy holds still, whatever the store does
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            lat.work_low <= FUSE_LOW_RST;
            lat.work_high <= FUSE_HIGH_RST;
            lat.work_ext <= FUSE_EXT_RST;
        end else if (lat.capture) begin
            lat.work_low <= lat.stored_low;
            lat.work_high <= lat.stored_high;
            lat.work_ext <= lat.stored_ext;
        end
    end

endmodule : fuse_working_latch

// ### rtl/fuse_signature_config_store.sv
// Fuse bytes, identity signature, trim byte and page geometry store
module fuse_signature_config_store
    import fuse_cfg_pkg::*;
#(
    parameter logic [7:0] TRIM_VALUE = 8'h80,  // Factory trim byte
    parameter logic [7:0] ID_BYTE_0 = 8'hA5,   // Arbitrary identity value
    parameter logic [7:0] ID_BYTE_1 = 8'h3C,   // Arbitrary identity value
    parameter logic [7:0] ID_BYTE_2 = 8'h71    // Arbitrary identity value
) (
    input wire logic clk_i,                                  // 50 MHz clock
    input wire logic reset_i,                                // Sync reset, high
    input wire logic prog_mode_pin_i,                        // Programming mode pin, async
    input wire logic serial_path_i,                          // 1 serial, 0 parallel
    input wire logic cmd_valid_i,                            // Command strobe
    input wire fuse_cfg_pkg::op_t cmd_op_i,                  // Command
    input wire fuse_cfg_pkg::sel_t cmd_sel_i,                // Fuse or lock byte select
    input wire logic [1:0] cmd_addr_i,                       // Signature address
    input wire logic cmd_upper_i,                            // Upper byte of signature word
    input wire logic [7:0] cmd_data_i,                       // Write data
    output logic rsp_valid_o,                                // Answer pulse
    output logic [7:0] rsp_data_o,                           // Read data
    output logic rsp_refused_o,                              // Command refused
    input wire logic [fuse_cfg_pkg::FLASH_ADDR_W-1:0] flash_addr_i,  // Flash word address
    output logic [fuse_cfg_pkg::FLASH_PAGE_BITS-1:0] flash_page_index_o,  // Page
    output logic [fuse_cfg_pkg::FLASH_WORD_BITS-1:0] flash_word_in_page_o, // Word in page
    input wire logic [fuse_cfg_pkg::EE_ADDR_W-1:0] eeprom_addr_i,        // EEPROM address
    output logic [fuse_cfg_pkg::EE_PAGE_BITS-1:0] eeprom_page_o,         // Page
    output logic [fuse_cfg_pkg::EE_BYTE_BITS-1:0] eeprom_byte_o,         // Byte in page
    output logic flash_erase_o,                              // Erase flash, pulse
    output logic eeprom_erase_o,                             // Erase EEPROM, pulse
    output logic [7:0] osc_tuning_reg_o,                     // Oscillator tuning
    output logic clock_divide_by_eight_o,                    // Prescale by 8
    output logic port_b_bit_zero_clk_sel_o,                  // Clock onto port pin
    output logic [1:0] startup_time_o,                       // Start-up time, raw
    output logic [3:0] clock_source_o,                       // Clock source, raw
    output logic [2:0] brownout_level_o,                     // Brown-out level, raw
    output logic watchdog_forced_on_o,                       // Watchdog always on
    output logic eeprom_keep_on_erase_o,                     // Keep EEPROM on erase
    output logic reset_pin_disable_o,                        // Reset pin off
    output logic single_wire_debug_on_o,                     // Debug link on
    output logic serial_prog_allow_o,                        // Serial programming on
    output logic [1:0] boot_area_size_o,                     // Boot size, raw
    output logic reset_vector_select_o,                      // Reset vector select
    output logic self_write_allow_o,                         // Self write allowed
    output logic memory_lock_first_o                         // First lock programmed
);
    import fuse_cfg_pkg::*;

    fuse_latch_if lif ();

    logic prog_meta_r;
    logic prog_sync_r;
    logic prog_prev_r;
    logic boot_capture_r;
    logic [7:0] low_config_byte_r;
    logic [7:0] high_config_byte_r;
    logic [7:0] extended_config_byte_r;
    logic [7:0] lock_r;
    logic cmd_go;
    logic fuses_locked;
    logic fuse_write_ok;
    logic [7:0] high_write_val;
    logic eeprom_keep_now;
    logic [7:0] read_nxt;
    logic refuse_nxt;

    // Two stages before anything looks at the pin
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            prog_meta_r <= 1'b0;
            prog_sync_r <= 1'b0;
            prog_prev_r <= 1'b0;
        end else begin
            prog_meta_r <= prog_mode_pin_i;
            prog_sync_r <= prog_meta_r;
            prog_prev_r <= prog_sync_r;
        end
    end

    // One capture right after power-up so the chip starts on the stored values
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            boot_capture_r <= 1'b1;
        end else begin
            boot_capture_r <= 1'b0;
        end
    end

    // Entry takes a fresh copy; exit releases what was written meanwhile
    assign lif.capture = boot_capture_r | (prog_sync_r ^ prog_prev_r);
    assign lif.stored_low = low_config_byte_r;
    assign lif.stored_high = high_config_byte_r;
    assign lif.stored_ext = extended_config_byte_r;

    fuse_working_latch u_latch (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .lat(lif.latch)
    );

    // Commands only count while programming mode is held
    assign cmd_go = cmd_valid_i & prog_sync_r;
    assign fuses_locked = ~lock_r[LOCK_FIRST];
    assign fuse_write_ok = cmd_go && (cmd_op_i == OP_WRITE_FUSE) && !fuses_locked
                           && (cmd_sel_i != SEL_LOCK);

    // The serial path cannot change the serial enable fuse
    always_comb begin
        high_write_val = cmd_data_i;
        if (serial_path_i) begin
            high_write_val[HI_SERIAL_PROG] = high_config_byte_r[HI_SERIAL_PROG];
        end
    end

    // Fuse bytes, reloaded with factory values on reset; chip erase has no path in here
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            low_config_byte_r <= FUSE_LOW_RST;
            high_config_byte_r <= FUSE_HIGH_RST;
            extended_config_byte_r <= FUSE_EXT_RST;
        end else if (fuse_write_ok) begin
            case (cmd_sel_i)
                SEL_LOW: begin
                    low_config_byte_r <= cmd_data_i;
                end
                SEL_HIGH: begin
                    high_config_byte_r <= high_write_val;
                end
                SEL_EXT: begin
                    extended_config_byte_r <= cmd_data_i;
                end
                default: begin
                    low_config_byte_r <= low_config_byte_r;
                end
            endcase
        end
    end

    // Lock bits only move toward programmed; chip erase and reset clear them
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            lock_r <= LOCK_RST;
        end else if (cmd_go && cmd_op_i == OP_CHIP_ERASE) begin
            lock_r <= LOCK_RST;
        end else if (cmd_go && cmd_op_i == OP_WRITE_LOCK) begin
            lock_r <= lock_r & cmd_data_i;
        end
    end

    // Keep-on-erase takes hold the moment the stored bit is programmed
    assign eeprom_keep_now = ~(lif.work_high[HI_EEPROM_KEEP] & high_config_byte_r[HI_EEPROM_KEEP]);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            flash_erase_o <= 1'b0;
            eeprom_erase_o <= 1'b0;
        end else begin
            flash_erase_o <= cmd_go && cmd_op_i == OP_CHIP_ERASE;
            eeprom_erase_o <= cmd_go && cmd_op_i == OP_CHIP_ERASE && !eeprom_keep_now;
        end
    end

    // Read path: raw fuse bits, zero meaning programmed
    always_comb begin
        read_nxt = BLANK_BYTE;
        refuse_nxt = !cmd_go;
        case (cmd_op_i)
            OP_READ_FUSE: begin
                case (cmd_sel_i)
                    SEL_LOW: begin
                        read_nxt = low_config_byte_r;
                    end
                    SEL_HIGH: begin
                        read_nxt = high_config_byte_r;
                        if (serial_path_i) begin
                            read_nxt[HI_SERIAL_PROG] = 1'b1;
                        end
                    end
                    SEL_EXT: begin
                        read_nxt = extended_config_byte_r;
                    end
                    default: begin
                        read_nxt = lock_r;
                    end
                endcase
            end
            OP_READ_SIG: begin
                // No lock check here: identity stays visible on both paths
                case (cmd_addr_i)
                    SIG_ADDR_0: begin
                        read_nxt = cmd_upper_i ? TRIM_VALUE : ID_BYTE_0;
                    end
                    SIG_ADDR_1: begin
                        read_nxt = ID_BYTE_1;
                    end
                    SIG_ADDR_2: begin
                        read_nxt = ID_BYTE_2;
                    end
                    default: begin
                        refuse_nxt = 1'b1;
                    end
                endcase
            end
            OP_WRITE_FUSE: begin
                refuse_nxt = !fuse_write_ok;
            end
            OP_CHIP_ERASE, OP_WRITE_LOCK: begin
                read_nxt = BLANK_BYTE;
            end
            default: begin
                refuse_nxt = 1'b1;
            end
        endcase
    end

    // Every strobe gets one answer on the next edge, refused or not
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rsp_valid_o <= 1'b0;
            rsp_data_o <= BLANK_BYTE;
            rsp_refused_o <= 1'b0;
        end else begin
            rsp_valid_o <= cmd_valid_i;
            rsp_data_o <= refuse_nxt ? BLANK_BYTE : read_nxt;
            rsp_refused_o <= cmd_valid_i & refuse_nxt;
        end
    end

    // Trim is reloaded on every reset; nothing else writes it here
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            osc_tuning_reg_o <= TRIM_VALUE;
        end
    end

    // Page split of incoming addresses
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            flash_page_index_o <= '0;
            flash_word_in_page_o <= '0;
            eeprom_page_o <= '0;
            eeprom_byte_o <= '0;
        end else begin
            flash_word_in_page_o <= flash_addr_i[FLASH_WORD_BITS-1:0];
            flash_page_index_o <= flash_addr_i[FLASH_ADDR_W-1:FLASH_WORD_BITS];
            eeprom_byte_o <= eeprom_addr_i[EE_BYTE_BITS-1:0];
            eeprom_page_o <= eeprom_addr_i[EE_ADDR_W-1:EE_BYTE_BITS];
        end
    end

    // Configuration outputs follow the working copy (keep-on-erase also the stored bit, lock the lock byte); single-bit flags active high when programmed
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            clock_divide_by_eight_o <= ~FUSE_LOW_RST[LO_CLK_DIV8];
            port_b_bit_zero_clk_sel_o <= ~FUSE_LOW_RST[LO_CLK_TO_PIN];
            startup_time_o <= FUSE_LOW_RST[LO_STARTUP_LSB+:2];
            clock_source_o <= FUSE_LOW_RST[LO_CLK_SRC_LSB+:4];
        end else begin
            clock_divide_by_eight_o <= ~lif.work_low[LO_CLK_DIV8];
            port_b_bit_zero_clk_sel_o <= ~lif.work_low[LO_CLK_TO_PIN];
            startup_time_o <= lif.work_low[LO_STARTUP_LSB+:2];
            clock_source_o <= lif.work_low[LO_CLK_SRC_LSB+:4];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            brownout_level_o <= FUSE_EXT_RST[EXT_BOD_LSB+:3];
            self_write_allow_o <= ~FUSE_EXT_RST[EXT_SELF_WRITE];
            watchdog_forced_on_o <= ~FUSE_HIGH_RST[HI_WDT_FORCED];
            eeprom_keep_on_erase_o <= ~FUSE_HIGH_RST[HI_EEPROM_KEEP];
        end else begin
            brownout_level_o <= lif.work_ext[EXT_BOD_LSB+:3];
            self_write_allow_o <= ~lif.work_ext[EXT_SELF_WRITE];
            watchdog_forced_on_o <= ~lif.work_high[HI_WDT_FORCED];
            eeprom_keep_on_erase_o <= eeprom_keep_now;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            reset_pin_disable_o <= ~FUSE_HIGH_RST[HI_RESET_PIN_DIS];
            single_wire_debug_on_o <= ~FUSE_HIGH_RST[HI_DEBUG_ON];
            serial_prog_allow_o <= ~FUSE_HIGH_RST[HI_SERIAL_PROG];
            boot_area_size_o <= FUSE_HIGH_RST[HI_BOOT_SIZE_LSB+:2];
            reset_vector_select_o <= ~FUSE_HIGH_RST[HI_RESET_VECTOR];
            memory_lock_first_o <= 1'b0;
        end else begin
            reset_pin_disable_o <= ~lif.work_high[HI_RESET_PIN_DIS];
            single_wire_debug_on_o <= ~lif.work_high[HI_DEBUG_ON];
            serial_prog_allow_o <= ~lif.work_high[HI_SERIAL_PROG];
            boot_area_size_o <= lif.work_high[HI_BOOT_SIZE_LSB+:2];
            reset_vector_select_o <= ~lif.work_high[HI_RESET_VECTOR];
            memory_lock_first_o <= fuses_locked;
        end
    end

endmodule : fuse_signature_config_store

// ### verif/fuse_store_chk.sv
// Port-level assertions for the fuse, signature and trim store
module fuse_store_chk
    import fuse_cfg_pkg::*;
#(
    parameter logic [7:0] TRIM_VALUE = 8'h80,
    parameter logic [7:0] ID_BYTE_0 = 8'hA5,
    parameter logic [7:0] ID_BYTE_1 = 8'h3C,
    parameter logic [7:0] ID_BYTE_2 = 8'h71
) (
    input wire logic clk_i, // Clock
    input wire logic reset_i, // Reset
    input wire logic prog_mode_pin_i, // Mode pin
    input wire logic serial_path_i, // Path
    input wire logic cmd_valid_i, // Strobe
    input wire fuse_cfg_pkg::op_t cmd_op_i, // Command
    input wire fuse_cfg_pkg::sel_t cmd_sel_i, // Select
    input wire logic [1:0] cmd_addr_i, // Address
    input wire logic cmd_upper_i, // Upper byte
    input wire logic rsp_valid_o, // Answer
    input wire logic [7:0] rsp_data_o, // Data
    input wire logic rsp_refused_o, // Refused
    input wire logic [fuse_cfg_pkg::FLASH_ADDR_W-1:0] flash_addr_i, // Address
    input wire logic [fuse_cfg_pkg::FLASH_PAGE_BITS-1:0] flash_page_index_o, // Page
    input wire logic [fuse_cfg_pkg::FLASH_WORD_BITS-1:0] flash_word_in_page_o, // Word
    input wire logic flash_erase_o, // Erase
    input wire logic eeprom_erase_o, // Erase
    input wire logic [7:0] osc_tuning_reg_o, // Tuning
    input wire logic watchdog_forced_on_o, // Watchdog
    input wire logic [3:0] clock_source_o, // Source
    input wire logic [2:0] brownout_level_o, // Level
    input wire logic eeprom_keep_on_erase_o, // Keep
    input wire logic memory_lock_first_o // Lock
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    logic pin_d_r;
    logic [3:0] quiet_r;
    // Saturated quiet_r: no latch event pending
    always_ff @(posedge clk_i) begin
        pin_d_r <= prog_mode_pin_i;
        if (reset_i || prog_mode_pin_i != pin_d_r) begin
            quiet_r <= 4'h0;
        end else if (quiet_r != 4'hF) begin
            quiet_r <= quiet_r + 4'h1;
        end
    end
    sequence s_ok;
        rsp_valid_o && !rsp_refused_o;
    endsequence
    sequence s_req(op);
        cmd_valid_i && cmd_op_i == op;
    endsequence
    a_lock_blocks_fuse: assert property (s_req(OP_WRITE_FUSE) ##0 (memory_lock_first_o && !$past(rsp_valid_o))
        |=> rsp_valid_o && rsp_refused_o) else $error("fuse write taken while locked");
    a_refused_blank: assert property (rsp_refused_o |-> rsp_valid_o && rsp_data_o == 8'hFF)
        else $error("refused answer not blank");
    a_sig_bytes: assert property ((s_req(OP_READ_SIG) ##0 !cmd_upper_i) ##1 s_ok |-> rsp_data_o ==
        ($past(cmd_addr_i) == SIG_ADDR_0 ? ID_BYTE_0 : $past(cmd_addr_i) == SIG_ADDR_1 ? ID_BYTE_1 : ID_BYTE_2))
        else $error("wrong identity byte");
    a_trim_read: assert property ((s_req(OP_READ_SIG) ##0 (cmd_upper_i && cmd_addr_i == SIG_ADDR_0)) ##1 s_ok
        |-> rsp_data_o == TRIM_VALUE) else $error("wrong trim byte");
    a_trim_reset: assert property ($fell(reset_i) |-> (osc_tuning_reg_o == TRIM_VALUE) [*3])
        else $error("tuning not loaded by reset");
    a_keep_stops_erase: assert property (eeprom_erase_o |-> flash_erase_o && !eeprom_keep_on_erase_o)
        else $error("eeprom erased while kept");
    a_erase_taken: assert property (s_req(OP_CHIP_ERASE) ##1 s_ok |-> flash_erase_o)
        else $error("accepted erase gave no flash pulse");
    a_cfg_quiet: assert property (quiet_r == 4'hF |-> $stable(watchdog_forced_on_o) && $stable(clock_source_o)
        && $stable(brownout_level_o)) else $error("config moved without latch event");
    a_flash_split: assert property (!$past(reset_i) |->
        {flash_page_index_o, flash_word_in_page_o} == $past(flash_addr_i)) else $error("flash split wrong");
    a_serial_hides: assert property ((s_req(OP_READ_FUSE) ##0 (serial_path_i && cmd_sel_i == SEL_HIGH)) ##1 s_ok
        |-> rsp_data_o[5] == 1'b1) else $error("serial enable visible on serial path");
endmodule : fuse_store_chk

// ### verif/prog_model.sv
// External programmer model driving the command port
module prog_model
    import fuse_cfg_pkg::*;
(
    input wire logic clk_i, // Clock
    output logic cmd_valid_o, // Strobe
    output fuse_cfg_pkg::op_t cmd_op_o, // Command
    output fuse_cfg_pkg::sel_t cmd_sel_o, // Select
    output logic [1:0] cmd_addr_o, // Signature address
    output logic cmd_upper_o, // Upper byte
    output logic [7:0] cmd_data_o, // Write data
    input wire logic rsp_valid_i, // Answer
    input wire logic [7:0] rsp_data_i, // Read data
    input wire logic rsp_refused_i, // Refused
    input wire logic flash_erase_i, // Erase pulse
    input wire logic eeprom_erase_i // Erase pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cmd_valid_o = 1'b0;
        cmd_op_o = OP_NONE;
        cmd_sel_o = SEL_LOW;
        cmd_addr_o = 2'h0;
        cmd_upper_o = 1'b0;
        cmd_data_o = 8'h00;
    end
    // One-cycle strobe, then a bounded wait; res is {eeprom erase, flash erase, refused, data}
    task automatic send(input op_t op, input sel_t sel, input logic [1:0] a, input logic up,
                        input logic [7:0] d, output logic [10:0] res, output logic ok);
        ok = 1'b0;
        res = 11'h000;
        @(negedge clk_i);
        cmd_valid_o = 1'b1;
        cmd_op_o = op;
        cmd_sel_o = sel;
        cmd_addr_o = a;
        cmd_upper_o = up;
        cmd_data_o = d;
        // The answer stands between rising edges, so it is taken at a falling one
        for (int n = 0; n < 4 && !ok; n++) begin
            @(negedge clk_i);
            if (rsp_valid_i === 1'b1) begin
                res = {eeprom_erase_i, flash_erase_i, rsp_refused_i, rsp_data_i};
                ok = 1'b1;
            end
            // Released address, upper and data lines show the inverse so late sampling cannot pass by luck; op and select keep their values
            cmd_valid_o = 1'b0;
            cmd_addr_o = ~a;
            cmd_upper_o = ~up;
            cmd_data_o = ~d;
        end
    endtask : send
endmodule : prog_model

// ### verif/fuse_signature_config_store_bench.sv
// Testbench for the fuse, signature and trim store
module fuse_signature_config_store_bench
    import fuse_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // Trim and identity values are arbitrary
    localparam logic [7:0] TRIM = 8'h9B;
    localparam logic [7:0] ID [3] = '{8'h5A, 8'hC3, 8'h17};
    localparam logic [13:0] FA [3] = '{14'h003F, 14'h0040, 14'h3FC1};
    localparam logic [9:0] EA [3] = '{10'h003, 10'h004, 10'h3FD};
    logic clk_i, reset_i, prog_mode_pin_i, serial_path_i, cmd_valid_i, cmd_upper_i;
    op_t cmd_op_i;
    sel_t cmd_sel_i;
    logic [1:0] cmd_addr_i, startup_time_o, boot_area_size_o, eeprom_byte_o;
    logic [7:0] cmd_data_i, rsp_data_o, osc_tuning_reg_o, flash_page_index_o, eeprom_page_o;
    logic rsp_valid_o, rsp_refused_o, flash_erase_o, eeprom_erase_o, clock_divide_by_eight_o;
    logic port_b_bit_zero_clk_sel_o, watchdog_forced_on_o, eeprom_keep_on_erase_o, reset_pin_disable_o;
    logic single_wire_debug_on_o, serial_prog_allow_o, reset_vector_select_o, self_write_allow_o;
    logic memory_lock_first_o;
    logic [13:0] flash_addr_i;
    logic [9:0] eeprom_addr_i;
    logic [5:0] flash_word_in_page_o;
    logic [3:0] clock_source_o;
    logic [2:0] brownout_level_o;
    logic [10:0] res;
    logic [20:0] cfg_w;
    int n_fail = 0;
    int n_compared = 0;
    assign cfg_w = {serial_prog_allow_o, clock_divide_by_eight_o, clock_source_o, brownout_level_o,
        watchdog_forced_on_o, port_b_bit_zero_clk_sel_o, eeprom_keep_on_erase_o, reset_pin_disable_o,
        single_wire_debug_on_o, boot_area_size_o, reset_vector_select_o, self_write_allow_o, startup_time_o,
        memory_lock_first_o};
    fuse_signature_config_store #(.TRIM_VALUE(TRIM), .ID_BYTE_0(ID[0]), .ID_BYTE_1(ID[1]), .ID_BYTE_2(ID[2]))
    dut_u (.*);
    prog_model prog_u (.clk_i, .cmd_valid_o(cmd_valid_i), .cmd_op_o(cmd_op_i), .cmd_sel_o(cmd_sel_i),
        .cmd_addr_o(cmd_addr_i), .cmd_upper_o(cmd_upper_i), .cmd_data_o(cmd_data_i), .rsp_valid_i(rsp_valid_o),
        .rsp_data_i(rsp_data_o), .rsp_refused_i(rsp_refused_o), .flash_erase_i(flash_erase_o),
        .eeprom_erase_i(eeprom_erase_o));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // Expected chip view, in cfg_w order, from raw fuse bytes where 0 means programmed
    function automatic logic [20:0] cfg_of(input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] ex,
                                           input logic [7:0] lk);
        return {~hi[5], ~lo[7], lo[3:0], ex[2:0], ~hi[4], ~lo[6], ~hi[3], ~hi[7], ~hi[6], hi[2:1], ~hi[0],
            ~ex[0], lo[5:4], ~lk[0]};
    endfunction : cfg_of
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic give_verdict();
        if (n_fail == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic cmd(input op_t op, input sel_t sel, input logic [10:0] exp, input logic [7:0] d = 8'h00,
                       input logic [1:0] a = 2'h0, input logic up = 1'b0);
        logic ok;
        prog_u.send(op, sel, a, up, d, res, ok);
        if (ok !== 1'b1) begin
            n_fail++;
            give_verdict();
        end else begin
            chk($sformatf("answer to %s", op.name()), exp, res);
        end
    endtask : cmd
    task automatic mode(input logic m);
        @(negedge clk_i);
        prog_mode_pin_i = m;
        repeat (8) @(negedge clk_i);
    endtask : mode
    task automatic do_reset();
        reset_i = 1'b1;
        repeat (2) @(negedge clk_i);
        reset_i = 1'b0;
        repeat (4) @(negedge clk_i);
    endtask : do_reset
    initial begin
        prog_mode_pin_i = 1'b0;
        serial_path_i = 1'b0;
        flash_addr_i = 14'h0000;
        eeprom_addr_i = 10'h000;
        do_reset();
        chk("config", cfg_of(8'h62, 8'hD9, 8'hFF, 8'hFF), cfg_w);
        chk("tuning", TRIM, osc_tuning_reg_o);
        cmd(OP_READ_SIG, SEL_LOW, 11'h1FF);
        mode(1'b1);
        for (int s = 0; s < 2; s++) begin
            @(negedge clk_i);
            serial_path_i = s[0];
            for (int a = 0; a < 3; a++) begin
                cmd(OP_READ_SIG, SEL_LOW, {3'h0, ID[a]}, 8'h00, a[1:0]);
            end
            cmd(OP_READ_SIG, SEL_LOW, {3'h0, TRIM}, 8'h00, 2'h0, 1'b1);
        end
        cmd(OP_READ_SIG, SEL_LOW, 11'h1FF, 8'h00, 2'h3);
        cmd(OP_READ_FUSE, SEL_HIGH, 11'h0F9);
        cmd(OP_WRITE_FUSE, SEL_HIGH, 11'h0FF, 8'hFF);
        @(negedge clk_i);
        serial_path_i = 1'b0;
        cmd(OP_READ_FUSE, SEL_HIGH, 11'h0DF);
        cmd(OP_READ_FUSE, SEL_LOW, 11'h062);
        cmd(OP_READ_FUSE, SEL_EXT, 11'h0FF);
        cmd(OP_CHIP_ERASE, SEL_LOW, 11'h6FF);
        cmd(OP_WRITE_FUSE, SEL_LOW, 11'h0FF, 8'h25);
        cmd(OP_WRITE_FUSE, SEL_EXT, 11'h0FF, 8'hFA);
        cmd(OP_WRITE_FUSE, SEL_HIGH, 11'h0FF, 8'hC1);
        repeat (2) @(negedge clk_i);
        chk("config", cfg_of(8'h62, 8'hD1, 8'hFF, 8'hFF), cfg_w);
        cmd(OP_CHIP_ERASE, SEL_LOW, 11'h2FF);
        cmd(OP_READ_FUSE, SEL_HIGH, 11'h0C1);
        cmd(OP_READ_FUSE, SEL_LOW, 11'h025);
        mode(1'b0);
        chk("config", cfg_of(8'h25, 8'hC1, 8'hFA, 8'hFF), cfg_w);
        mode(1'b1);
        // Lock goes in only after all accepted fuse writes; the fuse write after it is refused
        cmd(OP_WRITE_LOCK, SEL_LOCK, 11'h0FF, 8'hFE);
        cmd(OP_WRITE_FUSE, SEL_LOW, 11'h1FF);
        cmd(OP_READ_FUSE, SEL_LOCK, 11'h0FE);
        cmd(OP_READ_FUSE, SEL_LOW, 11'h025);
        chk("config", cfg_of(8'h25, 8'hC1, 8'hFA, 8'hFE), cfg_w);
        @(negedge clk_i);
        serial_path_i = 1'b1;
        cmd(OP_READ_SIG, SEL_LOW, {3'h0, ID[2]}, 8'h00, 2'h2);
        for (int i = 0; i < 3; i++) begin
            flash_addr_i = FA[i];
            eeprom_addr_i = EA[i];
            repeat (2) @(negedge clk_i);
            chk("flash page", FA[i][13:6], flash_page_index_o);
            chk("flash word", FA[i][5:0], flash_word_in_page_o);
            chk("eeprom page", EA[i][9:2], eeprom_page_o);
            chk("eeprom byte", EA[i][1:0], eeprom_byte_o);
        end
        do_reset();
        chk("config", cfg_of(8'h62, 8'hD9, 8'hFF, 8'hFF), cfg_w);
        chk("tuning", TRIM, osc_tuning_reg_o);
        give_verdict();
    end
endmodule : fuse_signature_config_store_bench

bind fuse_signature_config_store fuse_store_chk #(.TRIM_VALUE(TRIM_VALUE), .ID_BYTE_0(ID_BYTE_0),
    .ID_BYTE_1(ID_BYTE_1), .ID_BYTE_2(ID_BYTE_2)) chk_u (.*);
